// ===== hw/cmr_consts.svh
// constants for the collision and mode register slice
`ifndef CMR_CONSTS_SVH
`define CMR_CONSTS_SVH

// register indices; byte address is four times the index
`define CMR_IDX_COLL        6'h0E
`define CMR_IDX_RSVD_TAIL   6'h0F
`define CMR_IDX_RSVD_HEAD   6'h10
`define CMR_IDX_MODE        6'h11

// collision report field positions
`define CMR_COLL_KEEP_BIT   7
`define CMR_COLL_INVAL_BIT  5
`define CMR_COLL_POS_MSB    4

// mode register field positions
`define CMR_MODE_MSB_BIT    7
`define CMR_MODE_WAIT_BIT   5
`define CMR_MODE_POL_BIT    3
`define CMR_MODE_PRE_MSB    1

// reset values
`define CMR_COLL_RESET      8'hA0
`define CMR_MODE_RESET      8'h3F
`define CMR_RSVD_RESET      8'h00
`define CMR_MODE_RSVD_ONES  8'h14

// data-bit position limits
`define CMR_POS_MAX         6'h20
`define CMR_POS_SAT         6'h21

// crc presets for the compute command
`define CMR_PRESET_00       16'h0000
`define CMR_PRESET_01       16'h6363
`define CMR_PRESET_10       16'hA671
`define CMR_PRESET_11       16'hFFFF

// automatic presets during rf traffic
`define CMR_AUTO_PRESET_LOW  16'h6363
`define CMR_AUTO_PRESET_HIGH 16'h0000
`define CMR_RATE_106         3'h0
`define CMR_RATE_MSB         6

`endif

// ===== hw/cmr_pkg.sv
// types for the collision and mode register slice
`default_nettype none
package cmr_pkg;

  typedef struct packed {
    logic       keep_bits;
    logic       pos_invalid;
    logic [4:0] first_index;
  } cmr_coll_t;

  typedef struct packed {
    logic       msb_order;
    logic       wait_field;
    logic       env_polarity;
    logic [1:0] preset_sel;
  } cmr_mode_t;

  typedef struct packed {
    logic       strobe;
    logic       value;
    logic       collision;
  } cmr_rx_bit_t;

endpackage : cmr_pkg

`default_nettype wire

// ===== hw/cmr_regs.sv
// collision report and general mode registers with avalon-mm slave
//
// Functional notes
// - keep bit clear: bits after first collision are delivered as zero.
// - invalid flag set when no collision or collision beyond bit 32.
// - index holds position of the earliest collision in the frame.
// - index 01h is first bit, 08h eighth, 00h thirty-second.
// - parity and framing bits are not counted in the position.
// - registers 0Fh and 10h are reserved, read 00h, no function.
// - msb order bit makes standalone crc run msb first.
// - with msb order, both crc result bytes are bit reversed.
// - msb order is ignored while rf communication is active.
// - wait-for-field holds transmitter start until own field is on.
// - envelope pin active high when polarity is 1, low when 0.
// - internal envelope signal is always active low.
// - changing envelope polarity raises an envelope activity event.
// - compute preset chosen by select: 0000h, 6363h, A671h, FFFFh.
// - during rf traffic the preset follows tx and rx settings.
// - mode register resets to 3Fh; bits 6, 4, 2 do nothing.
// - tx and rx settings carry crc enable and 3-bit rate field.
//
// Decided for this implementation: the Avalon-MM slave port.
`include "cmr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module cmr_regs
  import cmr_pkg::*;
(
  // clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // receiver bit stream
  input  wire logic        rx_frame_start_in,
  input  wire cmr_rx_bit_t rx_data_bit_in,
  input  wire logic        rx_framing_bit_in,
  output logic             rx_bit_strobe_out,
  output logic             rx_bit_value_out,
  // crc engine
  input  wire logic [15:0] crc_engine_result_in,
  output logic             crc_msb_first_out,
  output logic      [15:0] crc_preset_out,
  output logic      [7:0]  crc_result_high_out,
  output logic      [7:0]  crc_result_low_out,
  // rf state and settings
  input  wire logic        rf_tx_active_in,
  input  wire logic        rf_rx_active_in,
  input  wire logic [7:0]  tx_settings_in,
  input  wire logic [7:0]  rx_settings_in,
  // transmitter start
  input  wire logic        tx_start_req_in,
  input  wire logic        rf_field_on_in,
  output logic             tx_start_out,
  // envelope input
  input  wire logic        envelope_input_pin_in,
  output logic             envelope_n_out,
  output logic             envelope_active_event_out
);

  cmr_coll_t   coll;
  cmr_mode_t   mode;
  logic        ack;
  logic        req;
  logic        wr_en;
  logic [5:0]  reg_idx;
  logic [7:0]  next_rdata;
  logic [5:0]  bit_count;
  logic [5:0]  next_count;
  logic        coll_seen;
  logic        rf_active;
  logic        tx_pending;
  logic        env_sync1;
  logic        env_sync2;
  logic        env_n_int;
  logic        env_n_prev;
  logic        pol_change;
  logic [2:0]  active_rate;

  function automatic logic [7:0] cmr_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : cmr_rev8

  // bus handshake: one wait state per access
  assign req     = avs_read_in | avs_write_in;
  assign reg_idx = avs_address_in[7:2];
  assign avs_waitrequest_out = req & ~ack;
  assign wr_en   = avs_write_in & ack & clk_en_in & avs_byteenable_in[0];
  assign rf_active = rf_tx_active_in | rf_rx_active_in;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack <= 1'b0;
    end else if (clk_en_in) begin
      ack <= req & ~ack;
    end
  end

  // read mux; unmapped and reserved addresses return zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_idx)
      `CMR_IDX_COLL: begin
        next_rdata[`CMR_COLL_KEEP_BIT]  = coll.keep_bits;
        next_rdata[`CMR_COLL_INVAL_BIT] = coll.pos_invalid;
        next_rdata[`CMR_COLL_POS_MSB:0] = coll.first_index;
      end
      `CMR_IDX_RSVD_TAIL: next_rdata = `CMR_RSVD_RESET;
      `CMR_IDX_RSVD_HEAD: next_rdata = `CMR_RSVD_RESET;
      `CMR_IDX_MODE: begin
        next_rdata = `CMR_MODE_RSVD_ONES;
        next_rdata[`CMR_MODE_MSB_BIT]    = mode.msb_order;
        next_rdata[`CMR_MODE_WAIT_BIT]   = mode.wait_field;
        next_rdata[`CMR_MODE_POL_BIT]    = mode.env_polarity;
        next_rdata[`CMR_MODE_PRE_MSB:0]  = mode.preset_sel;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (clk_en_in && avs_read_in && !ack) begin
      avs_readdata_out <= {24'h00_0000, next_rdata};
    end
  end

  // mode register; reserved bits are not stored
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mode.msb_order    <= 1'b0;
      mode.wait_field   <= 1'b1;
      mode.env_polarity <= 1'b1;
      mode.preset_sel   <= 2'h3;
      pol_change        <= 1'b0;
    end else if (clk_en_in) begin
      pol_change <= 1'b0;
      if (wr_en && reg_idx == `CMR_IDX_MODE) begin
        mode.msb_order    <= avs_writedata_in[`CMR_MODE_MSB_BIT];
        mode.wait_field   <= avs_writedata_in[`CMR_MODE_WAIT_BIT];
        mode.env_polarity <= avs_writedata_in[`CMR_MODE_POL_BIT];
        mode.preset_sel   <= avs_writedata_in[`CMR_MODE_PRE_MSB:0];
        pol_change <= avs_writedata_in[`CMR_MODE_POL_BIT]
                      != mode.env_polarity;
      end
    end
  end

  // data-bit counter; framing bits never reach it
  always_comb begin
    next_count = bit_count;
    if (rx_data_bit_in.strobe && bit_count != `CMR_POS_SAT) begin
      next_count = bit_count + 6'h01;
    end
  end

  // one process owns the whole collision report; keep bit is software-owned
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      coll.keep_bits   <= 1'(`CMR_COLL_RESET >> `CMR_COLL_KEEP_BIT);
      bit_count        <= 6'h00;
      coll_seen        <= 1'b0;
      coll.pos_invalid <= 1'b1;
      coll.first_index <= 5'h00;
    end else if (clk_en_in) begin
      if (wr_en && reg_idx == `CMR_IDX_COLL) begin
        coll.keep_bits <= avs_writedata_in[`CMR_COLL_KEEP_BIT];
      end
      if (rx_frame_start_in) begin
        bit_count        <= 6'h00;
        coll_seen        <= 1'b0;
        coll.pos_invalid <= 1'b1;
      end else if (rx_data_bit_in.strobe) begin
        bit_count <= next_count;
        if (rx_data_bit_in.collision && !coll_seen) begin
          coll_seen <= 1'b1;
          if (next_count <= `CMR_POS_MAX) begin
            coll.pos_invalid <= 1'b0;
            coll.first_index <= next_count[4:0];
          end else begin
            coll.pos_invalid <= 1'b1;
          end
        end
      end
    end
  end

  // bits after the first collision are zeroed unless kept
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_bit_strobe_out <= 1'b0;
      rx_bit_value_out  <= 1'b0;
    end else if (clk_en_in) begin
      rx_bit_strobe_out <= rx_data_bit_in.strobe & ~rx_frame_start_in;
      rx_bit_value_out  <= rx_data_bit_in.value &
                           ~(coll_seen & ~coll.keep_bits);
    end
  end

  // crc order and result presentation
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      crc_msb_first_out   <= 1'b0;
      crc_result_high_out <= 8'h00;
      crc_result_low_out  <= 8'h00;
    end else if (clk_en_in) begin
      crc_msb_first_out <= mode.msb_order & ~rf_active;
      if (mode.msb_order && !rf_active) begin
        crc_result_high_out <= cmr_rev8(crc_engine_result_in[15:8]);
        crc_result_low_out  <= cmr_rev8(crc_engine_result_in[7:0]);
      end else begin
        crc_result_high_out <= crc_engine_result_in[15:8];
        crc_result_low_out  <= crc_engine_result_in[7:0];
      end
    end
  end

  // preset: select during compute, rate-driven during rf traffic
  assign active_rate = rf_tx_active_in ?
    tx_settings_in[`CMR_RATE_MSB -: 3] :
    rx_settings_in[`CMR_RATE_MSB -: 3];

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      crc_preset_out <= `CMR_PRESET_11;
    end else if (clk_en_in) begin
      if (rf_active) begin
        crc_preset_out <= (active_rate == `CMR_RATE_106) ?
          `CMR_AUTO_PRESET_LOW : `CMR_AUTO_PRESET_HIGH;
      end else begin
        case (mode.preset_sel)
          2'h0:    crc_preset_out <= `CMR_PRESET_00;
          2'h1:    crc_preset_out <= `CMR_PRESET_01;
          2'h2:    crc_preset_out <= `CMR_PRESET_10;
          default: crc_preset_out <= `CMR_PRESET_11;
        endcase
      end
    end
  end

  // transmitter start held until the field is on
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_pending   <= 1'b0;
      tx_start_out <= 1'b0;
    end else if (clk_en_in) begin
      if ((tx_pending || tx_start_req_in) &&
          (!mode.wait_field || rf_field_on_in)) begin
        tx_start_out <= 1'b1;
        tx_pending   <= 1'b0;
      end else begin
        tx_start_out <= 1'b0;
        tx_pending   <= tx_pending | tx_start_req_in;
      end
    end
  end

  // envelope pin synchroniser and polarity
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      env_sync1 <= 1'b0;
      env_sync2 <= 1'b0;
    end else if (clk_en_in) begin
      env_sync1 <= envelope_input_pin_in;
      env_sync2 <= env_sync1;
    end
  end

  assign env_n_int = mode.env_polarity ? ~env_sync2 : env_sync2;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      env_n_prev                <= 1'b1;
      envelope_n_out            <= 1'b1;
      envelope_active_event_out <= 1'b0;
    end else if (clk_en_in) begin
      env_n_prev     <= env_n_int;
      envelope_n_out <= env_n_int;
      envelope_active_event_out <= pol_change |
                                   (env_n_prev & ~env_n_int);
    end
  end

  logic unused_ok;
  assign unused_ok = rx_framing_bit_in & (|avs_writedata_in[31:8]) &
                     (|avs_byteenable_in[3:1]) & (|tx_settings_in[7]) &
                     (|tx_settings_in[3:0]) & (|rx_settings_in[7]) &
                     (|rx_settings_in[3:0]);

endmodule : cmr_regs

`default_nettype wire

// ===== tb/cmr_regs_monitor.sv
// assertion checker for the collision and mode register slice
`timescale 1ns/1ps
`default_nettype none
module cmr_regs_monitor
  import cmr_pkg::*;
(
  input wire logic        core_clk_in, reset_in, clk_en_in, avs_read_in,
  input wire logic        avs_waitrequest_out, rx_frame_start_in,
  input wire logic [7:0]  avs_address_in, tx_settings_in,
  input wire logic [31:0] avs_readdata_out,
  input wire cmr_rx_bit_t rx_data_bit_in,
  input wire logic        rx_bit_strobe_out, crc_msb_first_out,
  input wire logic [15:0] crc_engine_result_in, crc_preset_out,
  input wire logic [7:0]  crc_result_high_out, crc_result_low_out,
  input wire logic        rf_tx_active_in, rf_rx_active_in,
  input wire logic        tx_start_req_in, rf_field_on_in, tx_start_out,
  input wire logic        envelope_active_event_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in || !clk_en_in);

  function automatic logic [7:0] rev8(input logic [7:0] v);
    return {<<{v}};
  endfunction : rev8

  AST_RSVD_ZERO: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in[7:2] inside
    {6'h0F, 6'h10} |-> avs_readdata_out == 32'h0)
    else $error("reserved register read not zero");
  AST_TX_NOW: assert property (
    tx_start_req_in && rf_field_on_in |=> tx_start_out)
    else $error("transmitter start missing");
  AST_CRC_RF_IGN: assert property (
    rf_tx_active_in || rf_rx_active_in |=> !crc_msb_first_out)
    else $error("msb order used during rf");
  AST_CRC_REV: assert property (
    $past(clk_en_in) && crc_msb_first_out |-> crc_result_high_out ==
    rev8($past(crc_engine_result_in[15:8])) && crc_result_low_out ==
    rev8($past(crc_engine_result_in[7:0])))
    else $error("crc result not reversed");
  AST_CRC_PLAIN: assert property (
    !crc_msb_first_out && !$past(reset_in) && $past(clk_en_in) |->
    {crc_result_high_out, crc_result_low_out} == $past(crc_engine_result_in))
    else $error("crc result altered");
  AST_PRESET_AUTO: assert property (
    rf_tx_active_in && tx_settings_in[6:4] == 3'h0 |=>
    crc_preset_out == 16'h6363)
    else $error("automatic preset wrong");
  AST_ENV_PULSE: assert property (
    envelope_active_event_out |=> !envelope_active_event_out)
    else $error("envelope event longer than one cycle");
  AST_RX_STROBE: assert property (
    rx_data_bit_in.strobe && !rx_frame_start_in |=> rx_bit_strobe_out)
    else $error("data bit not passed on");
  AST_RX_ONLY_DATA: assert property (
    $past(clk_en_in) && rx_bit_strobe_out |-> $past(rx_data_bit_in.strobe))
    else $error("bit strobe without data bit");
endmodule : cmr_regs_monitor

bind cmr_regs cmr_regs_monitor i_cmr_regs_monitor (
  .core_clk_in, .reset_in, .clk_en_in, .avs_read_in, .avs_waitrequest_out,
  .rx_frame_start_in, .avs_address_in, .tx_settings_in,
  .avs_readdata_out, .rx_data_bit_in, .rx_bit_strobe_out,
  .crc_msb_first_out, .crc_engine_result_in, .crc_preset_out,
  .crc_result_high_out, .crc_result_low_out, .rf_tx_active_in,
  .rf_rx_active_in, .tx_start_req_in, .rf_field_on_in, .tx_start_out,
  .envelope_active_event_out);
`default_nettype wire

// ===== tb/cmr_regs_tb_top.sv
// self-checking bench for the collision and mode register slice
`timescale 1ns/1ps
`default_nettype none
module cmr_regs_tb_top
  import cmr_pkg::*;
;
  // rows: address, write flag, write data, expected readback
  localparam logic [31:0] ROWS [11] = '{
    32'h3800_00A0, 32'h3C00_0000, 32'h4000_0000, 32'h4400_003F,
    32'h3C01_FF00, 32'h4001_FF00, 32'h4801_FF00, 32'h4401_FFBF,
    32'h4401_0014, 32'h3801_FFA0, 32'h3801_0020};
  localparam logic [15:0] PRE [4] = '{16'h0000, 16'h6363, 16'hA671,
                                      16'hFFFF};
  localparam int          POS [5] = '{1, 8, 32, 33, 40};
  logic        clk, rst, rd, wr, fs, fr, txa, rxa, req, fld, pin, en;
  logic [35:0] outs;
  logic        wq, bso, bvo, msb, txo, envn, evt;
  logic [3:0]  be;
  logic [7:0]  adr, txs, rxs, hi, lo;
  logic [15:0] crc, pre;
  logic [31:0] wd, rdo, q;
  cmr_rx_bit_t rb;
  int          n_errors, checks;

  cmr_regs i_cmr_regs (
    .core_clk_in(clk), .reset_in(rst), .clk_en_in(en),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wq),
    .rx_frame_start_in(fs), .rx_data_bit_in(rb), .rx_framing_bit_in(fr),
    .rx_bit_strobe_out(bso), .rx_bit_value_out(bvo),
    .crc_engine_result_in(crc), .crc_msb_first_out(msb),
    .crc_preset_out(pre), .crc_result_high_out(hi),
    .crc_result_low_out(lo), .rf_tx_active_in(txa),
    .rf_rx_active_in(rxa), .tx_settings_in(txs), .rx_settings_in(rxs),
    .tx_start_req_in(req), .rf_field_on_in(fld), .tx_start_out(txo),
    .envelope_input_pin_in(pin), .envelope_n_out(envn),
    .envelope_active_event_out(evt));

  assign outs = {msb, hi, lo, pre, envn, evt, txo};

  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic summarize();
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= {24'h0, d};
    @(posedge clk);
    while (wq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rows(input int n);
    for (int i = 0; i < n; i++) begin
      if (ROWS[i][16]) bus(1'b1, ROWS[i][31:24], ROWS[i][15:8]);
      bus(1'b0, ROWS[i][31:24], 8'h00);
      chk("register", ROWS[i][7:0], q);
    end
  endtask : rows

  // 34 data bits, collisions at p and p+2, one framing bit after bit 1
  task automatic frame(input int p, input logic k);
    logic [7:0] e;
    bus(1'b1, 8'h38, {k, 7'h00});
    @(posedge clk) fs <= 1'b1;
    @(posedge clk) fs <= 1'b0;
    for (int i = 1; i <= 34; i++) begin
      @(posedge clk) rb <= '{1'b1, 1'b1, i == p || i == p + 2};
      @(posedge clk) rb <= '0;
      fr <= (i == 1);
      #1 chk("rx_bit", {1'b1, !(i > p && !k)}, {bso, bvo});
    end
    bus(1'b0, 8'h38, 8'h00);
    e = (p > 32) ? {k, 7'h20} : {k, 2'b00, 5'(p)};
    chk("collision", e, q);
  endtask : frame

  task automatic txreq(input logic e);
    @(posedge clk) req <= 1'b1;
    @(posedge clk) req <= 1'b0;
    #1 chk("tx_start", e, txo);
  endtask : txreq

  task automatic crcchk(input logic [47:0] e);
    repeat (2) @(posedge clk);
    #1 chk("crc", e, {msb, hi, lo, pre});
  endtask : crcchk

  task automatic env(input logic e_n, input int e_c);
    int c;
    c = 0;
    repeat (8) begin
      @(posedge clk);
      #1 if (evt !== 1'b0) c++;
    end
    chk("env_event", e_c, c);
    chk("env_level", e_n, envn);
  endtask : env

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end

  initial begin
    {rd, wr, fs, fr, txa, rxa, req, fld, pin} <= '0;
    {adr, txs, rxs, wd, crc} <= '0;
    rst <= 1'b1;
    en  <= 1'b1;
    be  <= 4'hF;
    rb  <= '0;
    repeat (6) @(posedge clk);
    chk("reset_out", 36'h0_0007_FFFC, outs);
    rst <= 1'b0;
    rows(11);
    be <= 4'h0;
    bus(1'b1, 8'h44, 8'h3F);
    be <= 4'hF;
    bus(1'b0, 8'h44, 8'h00);
    chk("byte_enable", 8'h14, q);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h44, 8'(i));
      repeat (2) @(posedge clk);
      #1 chk("preset", PRE[i], pre);
    end
    for (int i = 0; i < 5; i++) frame(POS[i], i[0]);
    // wait-for-field: held, released by field, then immediate
    bus(1'b1, 8'h44, 8'h20);
    txreq(1'b0);
    repeat (3) @(posedge clk);
    #1 chk("tx_hold", 0, txo);
    @(posedge clk) fld <= 1'b1;
    @(posedge clk);
    #1 chk("tx_late", 1, txo);
    txreq(1'b1);
    @(posedge clk) fld <= 1'b0;
    bus(1'b1, 8'h44, 8'h00);
    txreq(1'b1);
    bus(1'b1, 8'h44, 8'h80);
    crc <= 16'h1234;
    crcchk(48'h1_482C_0000);
    @(posedge clk) rxa <= 1'b1;
    crcchk(48'h0_1234_6363);
    @(posedge clk) rxs <= 8'h10;
    crcchk(48'h0_1234_0000);
    @(posedge clk) txa <= 1'b1;
    crcchk(48'h0_1234_6363);
    @(posedge clk) {txa, rxa} <= 2'b00;
    bus(1'b1, 8'h44, 8'h08);
    env(1'b1, 1);
    @(posedge clk) pin <= 1'b1;
    env(1'b0, 1);
    bus(1'b1, 8'h44, 8'h08);
    env(1'b0, 0);
    bus(1'b1, 8'h44, 8'h00);
    env(1'b1, 1);
    // clock enable low freezes the crc output registers
    @(posedge clk) {en, crc} <= {1'b0, 16'hABCD};
    crcchk(48'h0_1234_0000);
    @(posedge clk) en <= 1'b1;
    crcchk(48'h0_ABCD_0000);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("reset_out", 36'h0_0007_FFFC, outs);
    rst <= 1'b0;
    rows(4);
    summarize();
  end
endmodule : cmr_regs_tb_top
`default_nettype wire
